/* File: common/lsd_defs.svh */
// Constants for the segment display driver: offsets, fields, codes and timing.
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH
// Register port widths.
`define LSD_AW 8
`define LSD_DW 24
// Register addresses; the three image words keep their printed offsets.
`define LSD_ADR_IMG0 8'h0d
`define LSD_ADR_IMG1 8'h0e
`define LSD_ADR_IMG2 8'h0f
`define LSD_ADR_CFG 8'h20
`define LSD_ADR_CMD 8'h21
`define LSD_ADR_ACCX 8'h22
`define LSD_ADR_ACCY 8'h23
`define LSD_ADR_STAT 8'h24
// Configuration word fields and reset value.
`define LSD_CFG_DUTY 1:0
`define LSD_CFG_FAST 3:2
`define LSD_CFG_LOAD1K 4
`define LSD_CFG_DIVRES 6:5
`define LSD_CFG_RECH 8:7
`define LSD_CFG_DIRECT 9
`define LSD_CFG_W 10
`define LSD_CFG_RST 10'h000
// Command word bits.
`define LSD_CMD_UPDATE 0
`define LSD_CMD_NUMCONV 1
`define LSD_CMD_DECSEG 2
// Segment image layout.
`define LSD_IMG_W 56
`define LSD_IMG2_W 8
`define LSD_SYM_LO 48
`define LSD_MASK_MUX2 56'h00_0000_ffff_ffff
`define LSD_MASK_MUX3 56'h00_1fff_ffff_ffff
`define LSD_MASK_MUX4 56'hff_ffff_ffff_ffff
`define LSD_CONV_DIGITS 6
`define LSD_SEG_DOT 7
`define LSD_DP_W 3
// Seven-segment codes, segment a in bit 0, dot in bit 7.
`define LSD_SEG_0 8'h3f
`define LSD_SEG_1 8'h06
`define LSD_SEG_2 8'h5b
`define LSD_SEG_3 8'h4f
`define LSD_SEG_4 8'h66
`define LSD_SEG_5 8'h6d
`define LSD_SEG_6 8'h7d
`define LSD_SEG_7 8'h07
`define LSD_SEG_8 8'h7f
`define LSD_SEG_9 8'h6f
`define LSD_SEG_BLANK 8'h00
// Drive levels and pin count.
`define LSD_LVL_GND 2'h0
`define LSD_LVL_THIRD 2'h1
`define LSD_LVL_TWO3 2'h2
`define LSD_LVL_FULL 2'h3
`define LSD_PINS 18
// Double-dabble adjust figures.
`define LSD_DD_LIMIT 4'h4
`define LSD_DD_ADD 4'h3
// Timing.
`define LSD_CLK_KHZ 125000
`define LSD_FAST_PERIOD_MS 10
`define LSD_DISP_TICK_US 2000
`endif

/* File: common/lsd_pkg.sv */
// Types and shared decode function of the segment display driver.
package lsd_pkg;
`include "lsd_defs.svh"
  // Multiplex selection as held in the duty field.
  typedef enum logic [1:0] {
    LSD_DUTY_OFF  = 2'b00,
    LSD_DUTY_MUX2 = 2'b01,
    LSD_DUTY_MUX3 = 2'b10,
    LSD_DUTY_MUX4 = 2'b11
  } lsd_duty_t;
  // Number converter states.
  typedef enum logic {
    LSD_CV_IDLE = 1'b0,
    LSD_CV_RUN  = 1'b1
  } lsd_cv_state_t;
  // Decimal digit to seven-segment code; values above nine show blank.
  function automatic logic [7:0] lsd_seg_of(input logic [3:0] d);
    case (d)
      4'h0: return `LSD_SEG_0;
      4'h1: return `LSD_SEG_1;
      4'h2: return `LSD_SEG_2;
      4'h3: return `LSD_SEG_3;
      4'h4: return `LSD_SEG_4;
      4'h5: return `LSD_SEG_5;
      4'h6: return `LSD_SEG_6;
      4'h7: return `LSD_SEG_7;
      4'h8: return `LSD_SEG_8;
      4'h9: return `LSD_SEG_9;
      default: return `LSD_SEG_BLANK;
    endcase
  endfunction
endpackage

/* File: hdl/lsd_lcd_driver.sv */
// Segment display driver top: register port, image latch, conversions, pump control.
//
// Summary of operation
// (R1) Fast-load field sets 10 ms low-ohmic periods.
// (R2) Load select picks 200 Ohm or 1 kOhm.
// (R3) Divider resistance field selects 30k to 800k.
// (R4) Recharge every first, second or fourth tick.
// (R5) Software keeps recharge zero in stretched modes.
// (R6) Every pin drives one of four levels.
// (R7) Digit byte holds segments a..g plus dot.
// (R8) One bit lights a segment, same all modes.
// (R9) Image digits 0..6 span words 13 to 15.
// (R10) Two-way multiplex uses lowest 32 image bits.
// (R11) Three-way uses 40 bits plus symbols 40-44.
// (R12) Decimal opcode turns nibble into segment code.
// (R13) Signed 24-bit value converts, leading zeros blank.
// (R14) Dot position from Y, X returned signed.
// (R15) Unused upper digits ignored per multiplex mode.
// (R16) Conversion keeps symbol byte untouched.
// (R17) Software issues update after changing the image.
// (R18) Duty field: off, two, three, four way.
// (R19) Direct drive: no regulation, no pump.
// (R20) Shown pattern changes only on update.
`timescale 1ns/1ns
`include "lsd_defs.svh"
module lsd_lcd_driver
  #(parameter int FAST_CYC = `LSD_FAST_PERIOD_MS * `LSD_CLK_KHZ,
    parameter int TICK_CYC = `LSD_DISP_TICK_US * (`LSD_CLK_KHZ / 1000))
  (input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    ce_i,
   input  wire logic [`LSD_AW-1:0]      addr_i,
   input  wire logic [`LSD_DW-1:0]      wdata_i,
   input  wire logic                    wr_i,
   input  wire logic                    rd_i,
   output logic [`LSD_DW-1:0]           rdata_o,
   output logic [2*`LSD_PINS-1:0]       lvl_o,
   output logic                         pump_recharge_o,
   output logic                         pump_load_1k_o,
   output logic [1:0]                   divider_res_o,
   output logic                         low_res_divider_o,
   output logic                         direct_drive_o,
   output logic                         pump_enable_o);
  import lsd_pkg::*;
  localparam int FCW = $clog2(FAST_CYC + 1);
  localparam int TCW = $clog2(TICK_CYC + 1);
  localparam int ND = 7;

  // Register group: software visible state.
  logic [`LSD_CFG_W-1:0] cfg_r, cfg_nxt;       // Configuration word.
  logic [`LSD_IMG_W-1:0] img_r, img_nxt;       // Working image, words 13 to 15.
  logic [`LSD_IMG_W-1:0] shown_r, shown_nxt;   // Latched image on the glass.
  lsd_duty_t             sduty_r, sduty_nxt;   // Latched multiplex mode.
  logic [`LSD_DW-1:0]    accx_r, accx_nxt;     // X accumulator.
  logic [`LSD_DW-1:0]    accy_r, accy_nxt;     // Y accumulator, dot position.
  logic [`LSD_DW-1:0]    rdata_r, rdata_nxt;   // Read data, one cycle late.
  logic                  switched;             // Latched mode changes now.

  // Timing group: fast load, display tick and pump control.
  logic [1:0]     flper_r, flper_nxt;   // Fast-load periods left.
  logic [FCW-1:0] flcyc_r, flcyc_nxt;   // Cycles inside one period.
  logic [TCW-1:0] tkcnt_r, tkcnt_nxt;   // Display tick divider.
  logic           tick_r, tick_nxt;     // One-cycle display tick.
  logic [1:0]     rc_r, rc_nxt;         // Recharge interval counter.
  logic [1:0]     rc_mask;              // Interval mask from the field.
  logic           rech_r, rech_nxt;
  logic           load1k_r, load1k_nxt;
  logic [1:0]     divres_r, divres_nxt;
  logic           direct_r, direct_nxt;
  logic           pumpen_r, pumpen_nxt;
  logic           lowres_r, lowres_nxt; // Fast-load window flag, registered.

  // Converter handshake and formatted digits.
  logic                    cv_start;
  logic                    cv_busy;
  logic                    cv_done;
  logic [4*ND-1:0]         cv_bcd;
  logic [8*`LSD_CONV_DIGITS-1:0] fmt;   // Digit codes from the converter.

  // Per-mode mask; unused digits of the smaller modes never reach the pins.
  function automatic logic [`LSD_IMG_W-1:0] mode_mask(input lsd_duty_t d);
    unique case (d)
      LSD_DUTY_OFF:  return '0;
      LSD_DUTY_MUX2: return `LSD_MASK_MUX2;  // [R10]
      LSD_DUTY_MUX3: return `LSD_MASK_MUX3;  // [R11]
      LSD_DUTY_MUX4: return `LSD_MASK_MUX4;  // [R15]
    endcase
  endfunction

  // Leading-zero blanking and dot placement of the converted digits.
  always_comb begin
    logic       lead;
    logic [3:0] dig;
    logic [7:0] code;
    int         dp;
    lead = 1'b1;
    dig = 4'h0;
    code = `LSD_SEG_BLANK;
    dp = int'(accy_r[`LSD_DP_W-1:0]);
    fmt = '0;
    for (int i = `LSD_CONV_DIGITS - 1; i >= 0; i--) begin
      dig = cv_bcd[4*i+:4];
      code = lsd_seg_of(dig);  // [R7]
      // Zeros left of the dot and of the first significant digit go dark.
      if (lead && dig == 4'h0 && i > dp && i != 0) begin
        code = `LSD_SEG_BLANK;  // [R13]
      end else begin
        lead = 1'b0;
      end
      if (i == dp && dp != 0) begin
        code[`LSD_SEG_DOT] = 1'b1;  // [R14]
      end
      fmt[8*i+:8] = code;
    end
  end

  // Register decode, commands and image handling.
  always_comb begin
    cfg_nxt = cfg_r;
    img_nxt = img_r;
    shown_nxt = shown_r;
    sduty_nxt = sduty_r;
    accx_nxt = accx_r;
    accy_nxt = accy_r;
    rdata_nxt = '0;
    cv_start = 1'b0;
    switched = 1'b0;
    if (wr_i) begin
      unique case (addr_i)
        `LSD_ADR_CFG:  cfg_nxt = wdata_i[`LSD_CFG_W-1:0];
        `LSD_ADR_IMG0: img_nxt[`LSD_DW-1:0] = wdata_i;  // [R9]
        `LSD_ADR_IMG1: img_nxt[2*`LSD_DW-1:`LSD_DW] = wdata_i;  // [R9]
        `LSD_ADR_IMG2: img_nxt[`LSD_IMG_W-1:2*`LSD_DW] = wdata_i[`LSD_IMG2_W-1:0];
        `LSD_ADR_ACCX: accx_nxt = wdata_i;
        `LSD_ADR_ACCY: accy_nxt = wdata_i;
        `LSD_ADR_CMD: begin
          if (wdata_i[`LSD_CMD_UPDATE]) begin
            // Take over the image and mode together, masked to the mode.
            sduty_nxt = lsd_duty_t'(cfg_r[`LSD_CFG_DUTY]);  // [R18]
            shown_nxt = img_r & mode_mask(sduty_nxt);  // [R20] [R15]
            switched = (sduty_nxt != sduty_r);
          end
          // A new conversion is refused while one is still running.
          if (wdata_i[`LSD_CMD_NUMCONV] && !cv_busy) begin
            cv_start = 1'b1;
          end
          if (wdata_i[`LSD_CMD_DECSEG]) begin
            accx_nxt = {{(`LSD_DW-8){1'b0}}, lsd_seg_of(accx_r[3:0])};  // [R12]
          end
        end
        default: ;
      endcase
    end
    // Finished conversion lands in the low digits; the symbol byte stays.
    // It wins over a software write to the same words in that cycle.
    if (cv_done) begin
      img_nxt[`LSD_SYM_LO-1:0] = fmt;  // [R13] [R16]
    end
    if (rd_i) begin
      unique case (addr_i)
        `LSD_ADR_CFG:  rdata_nxt = {{(`LSD_DW-`LSD_CFG_W){1'b0}}, cfg_r};
        `LSD_ADR_IMG0: rdata_nxt = img_r[`LSD_DW-1:0];
        `LSD_ADR_IMG1: rdata_nxt = img_r[2*`LSD_DW-1:`LSD_DW];
        `LSD_ADR_IMG2: rdata_nxt = {{(`LSD_DW-`LSD_IMG2_W){1'b0}},
                                    img_r[`LSD_IMG_W-1:2*`LSD_DW]};
        `LSD_ADR_ACCX: rdata_nxt = accx_r;  // [R14]
        `LSD_ADR_ACCY: rdata_nxt = accy_r;
        `LSD_ADR_STAT: rdata_nxt = {{(`LSD_DW-4){1'b0}}, low_res_divider_o,
                                    sduty_r, cv_busy};
        default:       rdata_nxt = '0;
      endcase
    end
  end

  // Register group flip-flops.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= `LSD_CFG_RST;
      img_r <= '0;
      shown_r <= '0;
      sduty_r <= LSD_DUTY_OFF;
      accx_r <= '0;
      accy_r <= '0;
      rdata_r <= '0;
    end else if (ce_i) begin
      cfg_r <= cfg_nxt;
      img_r <= img_nxt;
      shown_r <= shown_nxt;
      sduty_r <= sduty_nxt;
      accx_r <= accx_nxt;
      accy_r <= accy_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata_o = rdata_r;

  // The signed X value is converted as is; X itself is never altered.
  lsd_num_convert #(
    .VW (`LSD_DW),
    .ND (ND)
  ) u_conv (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .start_i (cv_start),
    .value_i (accx_r),
    .busy_o  (cv_busy),
    .done_o  (cv_done),
    .bcd_o   (cv_bcd)
  );

  // Pin waveforms follow only the latched image and mode.
  lsd_level_gen u_lvl (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .tick_i (tick_r),
    .duty_i (sduty_r),
    .img_i  (shown_r),
    .lvl_o  (lvl_o)
  );

  // Timing and pump control next values.
  always_comb begin
    flper_nxt = flper_r;
    flcyc_nxt = flcyc_r;
    tkcnt_nxt = tkcnt_r + 1'b1;
    tick_nxt = 1'b0;
    rc_nxt = rc_r;
    // A value of three is taken as every fourth tick as well.
    rc_mask = (cfg_r[`LSD_CFG_RECH] == 2'b00) ? 2'b00 :
              (cfg_r[`LSD_CFG_RECH] == 2'b01) ? 2'b01 : 2'b11;  // [R4]
    if (tkcnt_r == TCW'(TICK_CYC - 1)) begin
      tkcnt_nxt = '0;
      tick_nxt = 1'b1;
    end
    if (tick_r) begin
      rc_nxt = rc_r + 2'b01;
    end
    // Switching the mode restarts the low-ohmic divider window.
    if (switched) begin
      flper_nxt = cfg_r[`LSD_CFG_FAST];  // [R1]
      flcyc_nxt = '0;
    end else if (flper_r != 2'b00) begin
      if (flcyc_r == FCW'(FAST_CYC - 1)) begin
        flcyc_nxt = '0;
        flper_nxt = flper_r - 2'b01;  // [R1]
      end else begin
        flcyc_nxt = flcyc_r + 1'b1;
      end
    end
    direct_nxt = cfg_r[`LSD_CFG_DIRECT];
    // Direct drive powers the glass from the supply: pump settings idle.
    pumpen_nxt = (sduty_r != LSD_DUTY_OFF) && !direct_nxt;  // [R19]
    rech_nxt = tick_r && pumpen_nxt && ((rc_r & rc_mask) == 2'b00);  // [R4] [R19]
    load1k_nxt = cfg_r[`LSD_CFG_LOAD1K] && !direct_nxt;  // [R2]
    divres_nxt = cfg_r[`LSD_CFG_DIVRES];  // [R3]
    // Registered so the pin leaves a flip-flop; stays in step with flper_r.
    lowres_nxt = (flper_nxt != 2'b00);  // [R1]
  end

  // Timing group flip-flops.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flper_r <= 2'b00;
      flcyc_r <= '0;
      tkcnt_r <= '0;
      tick_r <= 1'b0;
      rc_r <= 2'b00;
      rech_r <= 1'b0;
      load1k_r <= 1'b0;
      divres_r <= 2'b00;
      direct_r <= 1'b0;
      pumpen_r <= 1'b0;
      lowres_r <= 1'b0;
    end else if (ce_i) begin
      flper_r <= flper_nxt;
      flcyc_r <= flcyc_nxt;
      tkcnt_r <= tkcnt_nxt;
      tick_r <= tick_nxt;
      rc_r <= rc_nxt;
      rech_r <= rech_nxt;
      load1k_r <= load1k_nxt;
      divres_r <= divres_nxt;
      direct_r <= direct_nxt;
      pumpen_r <= pumpen_nxt;
      lowres_r <= lowres_nxt;
    end
  end
  assign pump_recharge_o = rech_r;
  assign pump_load_1k_o = load1k_r;
  assign divider_res_o = divres_r;
  assign low_res_divider_o = lowres_r;
  assign direct_drive_o = direct_r;
  assign pump_enable_o = pumpen_r;

  // Checks on the behaviour above.
  a_shown_hold: assert property (@(posedge clk_i) disable iff (rst_i)  // [R20]
    !(wr_i && addr_i == `LSD_ADR_CMD && wdata_i[`LSD_CMD_UPDATE]) |=> $stable(shown_r))
    else $error("Shown image changed without update.");
  a_shown_take: assert property (@(posedge clk_i) disable iff (rst_i)  // [R17]
    (ce_i && wr_i && addr_i == `LSD_ADR_CMD && wdata_i[`LSD_CMD_UPDATE])
    |=> shown_r == ($past(img_r) & mode_mask(sduty_r)))
    else $error("Update did not latch the image.");
  a_mux2_mask: assert property (@(posedge clk_i) disable iff (rst_i)  // [R10]
    sduty_r == LSD_DUTY_MUX2 |-> shown_r[`LSD_IMG_W-1:32] == '0)
    else $error("Two-way mode shows bits above 31.");
  a_mux3_mask: assert property (@(posedge clk_i) disable iff (rst_i)  // [R11]
    sduty_r == LSD_DUTY_MUX3 |-> shown_r[`LSD_IMG_W-1:45] == '0)
    else $error("Three-way mode shows bits above 44.");
  a_sym_keep: assert property (@(posedge clk_i) disable iff (rst_i)  // [R16]
    (ce_i && cv_done && !(wr_i && addr_i == `LSD_ADR_IMG2))
    |=> $stable(img_r[`LSD_IMG_W-1:`LSD_SYM_LO]))
    else $error("Conversion touched the symbol byte.");
  a_dec_code: assert property (@(posedge clk_i) disable iff (rst_i)  // [R12]
    (ce_i && wr_i && addr_i == `LSD_ADR_CMD && wdata_i[`LSD_CMD_DECSEG])
    |=> accx_r[7:0] == lsd_seg_of($past(accx_r[3:0])))
    else $error("Decimal opcode gave a wrong code.");
  a_conv_time: assert property (@(posedge clk_i) disable iff (rst_i)  // [R13]
    (ce_i && cv_start) |-> ##[24:200] cv_done)
    else $error("Conversion did not finish in time.");
  a_direct_nopump: assert property (@(posedge clk_i) disable iff (rst_i)  // [R19]
    direct_drive_o |-> !pump_recharge_o && !pump_load_1k_o)
    else $error("Pump active in direct drive.");
  a_div_res: assert property (@(posedge clk_i) disable iff (rst_i)  // [R3]
    ce_i |=> divider_res_o == $past(cfg_r[`LSD_CFG_DIVRES]))
    else $error("Divider resistance does not follow the field.");
  a_rech_every: assert property (@(posedge clk_i) disable iff (rst_i)  // [R4]
    (ce_i && tick_r && pumpen_r && cfg_r[`LSD_CFG_RECH] == 2'b00
     && !direct_nxt && sduty_r != LSD_DUTY_OFF) |=> pump_recharge_o)
    else $error("Recharge missed with interval zero.");
  c_update: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == `LSD_ADR_CMD && wdata_i[`LSD_CMD_UPDATE]);
  c_conv_done: cover property (@(posedge clk_i) disable iff (rst_i) cv_done);
  c_fast_load: cover property (@(posedge clk_i) disable iff (rst_i) low_res_divider_o);
  c_recharge: cover property (@(posedge clk_i) disable iff (rst_i) pump_recharge_o);
endmodule // lsd_lcd_driver

/* File: hdl/lsd_level_gen.sv */
// Four-level common and segment waveform generator for 2, 3 and 4 way multiplex.
`timescale 1ns/1ns
`include "lsd_defs.svh"
module lsd_level_gen
  (input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      ce_i,
   input  wire logic                      tick_i,
   input  wire lsd_pkg::lsd_duty_t        duty_i,
   input  wire logic [`LSD_IMG_W-1:0]     img_i,
   output logic [2*`LSD_PINS-1:0]         lvl_o);
  import lsd_pkg::*;
  logic [1:0]              com_r, com_nxt;  // Active common.
  logic                    pol_r, pol_nxt;  // Half frame polarity.
  logic [2*`LSD_PINS-1:0]  lvl_r, lvl_nxt;  // Registered pin levels.
  // Pins below the common count are commons, the rest are segment lines.
  always_comb begin
    int ncom;
    int idx;
    ncom = int'(duty_i) + 1;
    idx = 0;
    pol_nxt = pol_r;
    com_nxt = com_r;
    if (tick_i) begin
      pol_nxt = ~pol_r;
      if (pol_r) begin
        com_nxt = (com_r >= duty_i) ? 2'b00 : com_r + 2'b01;
      end
    end
    for (int p = 0; p < `LSD_PINS; p++) begin
      idx = (p - ncom) * ncom + int'(com_r);
      if (duty_i == LSD_DUTY_OFF) begin
        lvl_nxt[2*p+:2] = `LSD_LVL_GND;  // [R18]
      end else if (p < ncom) begin
        if (p == int'(com_r)) begin
          lvl_nxt[2*p+:2] = pol_r ? `LSD_LVL_FULL : `LSD_LVL_GND;  // [R6]
        end else begin
          lvl_nxt[2*p+:2] = pol_r ? `LSD_LVL_THIRD : `LSD_LVL_TWO3;  // [R6]
        end
      end else if (idx < `LSD_IMG_W && img_i[idx]) begin
        lvl_nxt[2*p+:2] = pol_r ? `LSD_LVL_GND : `LSD_LVL_FULL;  // [R8]
      end else begin
        lvl_nxt[2*p+:2] = pol_r ? `LSD_LVL_TWO3 : `LSD_LVL_THIRD;  // [R8]
      end
    end
  end
  // Registers, frozen while the clock enable is low.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      com_r <= 2'b00;
      pol_r <= 1'b0;
      lvl_r <= '0;
    end else if (ce_i) begin
      com_r <= com_nxt;
      pol_r <= pol_nxt;
      lvl_r <= lvl_nxt;
    end
  end
  assign lvl_o = lvl_r;
  a_off_ground: assert property (@(posedge clk_i) disable iff (rst_i)  // [R18]
    (ce_i && duty_i == LSD_DUTY_OFF) |=> lvl_r == '0)
    else $error("Pins not grounded while display is off.");
endmodule // lsd_level_gen

/* File: hdl/lsd_num_convert.sv */
// Sequential signed binary to BCD converter (shift and add three).
`timescale 1ns/1ns
`include "lsd_defs.svh"
module lsd_num_convert
  #(parameter int VW = 24,
    parameter int ND = 7)
  (input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic              start_i,
   input  wire logic [VW-1:0]     value_i,
   output logic                   busy_o,
   output logic                   done_o,
   output logic [4*ND-1:0]        bcd_o);
  import lsd_pkg::*;
  localparam int CW = $clog2(VW);
  lsd_cv_state_t   st_r, st_nxt;    // Converter state.
  logic [VW-1:0]   mag_r, mag_nxt;  // Magnitude being shifted out.
  logic [4*ND-1:0] bcd_r, bcd_nxt;  // Decimal digits being built.
  logic [4*ND-1:0] adj;             // Digits after the add-three step.
  logic [CW-1:0]   cnt_r, cnt_nxt;  // Bits shifted so far.
  logic            done_r, done_nxt;
  // One bit per cycle; the magnitude is taken so the sign never enters.
  always_comb begin
    st_nxt = st_r;
    mag_nxt = mag_r;
    bcd_nxt = bcd_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    adj = bcd_r;
    unique case (st_r)
      LSD_CV_IDLE: begin
        if (start_i) begin
          mag_nxt = value_i[VW-1] ? (~value_i + 1'b1) : value_i;
          bcd_nxt = '0;
          cnt_nxt = '0;
          st_nxt = LSD_CV_RUN;
        end
      end
      LSD_CV_RUN: begin
        for (int i = 0; i < ND; i++) begin
          if (adj[4*i+:4] > `LSD_DD_LIMIT) begin
            adj[4*i+:4] = adj[4*i+:4] + `LSD_DD_ADD;
          end
        end
        bcd_nxt = {adj[4*ND-2:0], mag_r[VW-1]};
        mag_nxt = {mag_r[VW-2:0], 1'b0};
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CW'(VW-1)) begin
          st_nxt = LSD_CV_IDLE;
          done_nxt = 1'b1;
        end
      end
    endcase
  end
  // State registers, frozen while the clock enable is low.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= LSD_CV_IDLE;
      mag_r <= '0;
      bcd_r <= '0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      mag_r <= mag_nxt;
      bcd_r <= bcd_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end
  assign busy_o = (st_r == LSD_CV_RUN);
  assign done_o = done_r;
  assign bcd_o = bcd_r;
endmodule // lsd_num_convert

/* File: verif/lsd_glass_model.sv */
// Behavioural display glass that rebuilds the lit segment map from drive levels.
`timescale 1ns/1ns
module lsd_glass_model (
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  input  wire logic [1:0]  duty_i,
  input  wire logic [35:0] lvl_i,
  output logic      [55:0] img_o
);
  // A segment is lit when its line sits at the opposite rail of an active common.
  // Commons at 1/3 or 2/3 are idle, so their segments are left as last seen.
  always @(posedge clk_i) begin : look
    int n;
    n = int'(duty_i) + 1;
    if (clr_i) begin
      img_o <= 56'h0;
    end else begin
      for (int c = 0; c < n; c++) begin
        if (lvl_i[2*c+:2] inside {2'h0, 2'h3}) begin
          for (int s = 0; s + n < 18; s++) begin
            img_o[s*n+c] <= (lvl_i[2*(s+n)+:2] == ~lvl_i[2*c+:2]);
          end
        end
      end
    end
  end
endmodule // lsd_glass_model

/* File: verif/lsd_lcd_driver_tb.sv */
// Self-checking bench of the segment display driver.
`timescale 1ns/1ns
`include "lsd_defs.svh"
module lsd_lcd_driver_tb;
  import lsd_pkg::*;
  logic        clk_i, rst_i, wr_i, rd_i, clr, rch, l1k, lowr, ddr, pen, ce;
  logic [7:0]  addr_i;
  logic [23:0] wdata_i, rdata_o, rv;
  logic [35:0] lvl_o;
  logic [1:0]  dres, gduty;
  logic [55:0] gimg;
  logic [55:0] img = {8'hab, 24'h5a0ff0, 24'ha5c33c};
  logic [55:0] mask [4] = '{56'h0, `LSD_MASK_MUX2, `LSD_MASK_MUX3, `LSD_MASK_MUX4};
  logic [7:0]  seg [11] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                            8'h7f, 8'h6f, 8'h00};
  int          failures, n_compared, hi_cnt, pulses, k;
  int          order [3] = '{3, 1, 2};
  // Short counts keep a fast-load period at 20 cycles and a tick at 8.
  lsd_lcd_driver #(.FAST_CYC(20), .TICK_CYC(8)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .lvl_o(lvl_o), .pump_recharge_o(rch), .pump_load_1k_o(l1k),
    .divider_res_o(dres), .low_res_divider_o(lowr), .direct_drive_o(ddr),
    .pump_enable_o(pen));
  lsd_glass_model GLASS (.clk_i(clk_i), .clr_i(clr), .duty_i(gduty), .lvl_i(lvl_o),
    .img_o(gimg));
  // Clock of 8 ns.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Counters of fast-load cycles and recharge pulses; the falling edge keeps
  // them clear of the bench's own clearing at the rising edge.
  always @(negedge clk_i) begin
    if (lowr === 1'b1) hi_cnt++;
    if (rch === 1'b1) pulses++;
  end
  // One-cycle write strobe; the gap cycle avoids a double assignment.
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Let the level pipeline settle, wipe the glass, then watch a few frames.
  task automatic show;
    repeat (4) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (200) @(posedge clk_i);
  endtask
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {rst_i, ce, wr_i, rd_i, clr, addr_i, wdata_i, gduty} = {2'b11, 37'h0};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h30);
    chk(56'(rv), 56'h0);
    wr(`LSD_ADR_IMG0, img[23:0]);
    wr(`LSD_ADR_IMG1, img[47:24]);
    wr(`LSD_ADR_IMG2, 24'hffffab);
    rd(`LSD_ADR_IMG2);
    chk(56'(rv), 56'hab);
    wr(`LSD_ADR_CFG, 24'h00000b);
    show();
    chk(gimg, 56'h0);
    // Each pass changes the mode, so the fast-load window reopens for 2 periods.
    foreach (order[i]) begin
      wr(`LSD_ADR_CFG, 24'(8 + order[i]));
      hi_cnt = 0;
      wr(`LSD_ADR_CMD, 24'h1);
      gduty = 2'(order[i]);
      show();
      chk(gimg, img & mask[order[i]]);
      chk(56'(hi_cnt), 56'h28);
    end
    wr(`LSD_ADR_IMG0, 24'h0);
    show();
    chk(gimg, img & mask[2]);
    for (int d = 0; d < 11; d++) begin
      wr(`LSD_ADR_ACCX, 24'habcde0 | 24'(d));
      wr(`LSD_ADR_CMD, 24'h4);
      rd(`LSD_ADR_ACCX);
      chk(56'(rv), 56'(seg[d]));
    end
    wr(`LSD_ADR_ACCX, 24'h0004d2);
    wr(`LSD_ADR_ACCY, 24'h2);
    wr(`LSD_ADR_CMD, 24'h2);
    k = 0;
    do begin
      rd(`LSD_ADR_STAT);
      k++;
      if (k > 100) begin
        failures++;
        conclude();
      end
    end while (rv[0] !== 1'b0);
    chk(56'(rv), 56'h4);
    repeat (4) @(posedge clk_i);
    rd(`LSD_ADR_IMG0);
    chk(56'(rv), 56'hdb4f66);
    rd(`LSD_ADR_IMG1);
    chk(56'(rv), 56'h000006);
    rd(`LSD_ADR_IMG2);
    chk(56'(rv), 56'hab);
    rd(`LSD_ADR_ACCX);
    chk(56'(rv), 56'h0004d2);
    // A write while the clock enable is low must leave Y untouched.
    @(posedge clk_i);
    ce <= 1'b0;
    wr(`LSD_ADR_ACCY, 24'h5);
    ce <= 1'b1;
    rd(`LSD_ADR_ACCY);
    chk(56'(rv), 56'h2);
    // Mode stays 3-way; only the recharge interval moves, stretched modes unused.
    for (int r = 0; r < 3; r++) begin
      wr(`LSD_ADR_CFG, 24'((r << 7) | 8'h52));
      repeat (16) @(posedge clk_i);
      pulses = 0;
      repeat (512) @(posedge clk_i);
      chk(56'(pulses), 56'(64 >> r));
      chk(56'({dres, l1k, pen, ddr}), 56'h16);
    end
    wr(`LSD_ADR_CFG, 24'h252);
    repeat (16) @(posedge clk_i);
    pulses = 0;
    repeat (64) @(posedge clk_i);
    chk(56'({pulses[3:0], l1k, ddr, pen}), 56'h2);
    wr(`LSD_ADR_CFG, 24'h0);
    wr(`LSD_ADR_CMD, 24'h1);
    repeat (8) @(posedge clk_i);
    chk(56'(lvl_o), 56'h0);
    conclude();
  end
endmodule // lsd_lcd_driver_tb
